// File: hdl/event_status_lock_regs.sv
`timescale 1ns/1ps
`default_nettype none
module event_status_lock_regs
  import event_status_lock_pkg::*;
#(
  parameter int unsigned CYCLE_DELAY = CYCLE_DELAY_CYCLES,
  parameter logic [6:0]  SLAVE_ADDR  = SLAVE_ADDR_RESET
) (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       scl,
  input  wire logic       sdaIn,
  output var  logic       sdaOut,
  output var  logic       sdaOe,
  input  wire logic       powerKeyPin,
  input  wire logic       converterCurrentAlarmLive,
  input  wire logic       thermalWarnLive,
  input  wire logic       inputLowWarnLive,
  input  wire logic       converterGoodLive,
  input  wire logic       genInput1Level,
  input  wire logic       genInput0Level,
  input  wire logic       longPressDetect,
  input  wire logic       rampupFailure,
  input  wire logic       inputUndervoltageFault,
  input  wire logic       converterOvercurrentFault,
  input  wire logic       overtemperatureFault,
  input  wire logic       softwarePowerCycleCtrl,
  input  wire logic       inputCycleRequest,
  input  wire logic       keyEdgeSelect,
  input  wire logic [1:0] genInputActiveHigh,
  output var  logic       interruptOutN,
  output var  logic       powerCycleRequest,
  output var  logic [7:0] thresholdCfg
);

  logic [NUM_ASYNC-1:0] asyncIn;
  logic [NUM_ASYNC-1:0] sync1_reg;
  logic [NUM_ASYNC-1:0] sync2_reg;
  logic [NUM_ASYNC-1:0] prev_reg;
  logic [NUM_ASYNC-1:0] rise;
  logic [NUM_ASYNC-1:0] fall;

  logic [7:0]  mask_reg;
  logic [7:0]  event_reg;
  logic [7:0]  fault_reg;
  logic [7:0]  thresh_reg;
  logic        unlocked_reg;
  logic        bootPending_reg;
  logic        cycleArmed_reg;
  logic [31:0] cycleCount_reg;
  logic        cycleFire_reg;
  logic        irqN_reg;

  bus_state_t  state_reg;
  bus_phase_t  phase_reg;
  logic [3:0]  bitCount_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  pointer_reg;
  logic        readMode_reg;
  logic        sdaOe_reg;

  logic        sclRise;
  logic        sclFall;
  logic        busStart;
  logic        busStop;
  logic        wrStrobe;
  logic [7:0]  rdData;
  logic [7:0]  liveStatus;
  logic [7:0]  eventSet;
  logic [7:0]  eventClr;
  logic [7:0]  faultSet;
  logic        keyEvent;
  logic        byteDone;

  assign asyncIn = {scl, sdaIn, powerKeyPin, converterCurrentAlarmLive,
                    thermalWarnLive, inputLowWarnLive, converterGoodLive,
                    genInput1Level, genInput0Level, longPressDetect,
                    rampupFailure, inputUndervoltageFault,
                    converterOvercurrentFault, overtemperatureFault,
                    softwarePowerCycleCtrl, inputCycleRequest};

  // Two-stage synchronisers, third stage for edge finding and the SCL-high check of start and stop
  genvar gi;
  generate
    for (gi = 0; gi < NUM_ASYNC; gi++) begin : g_sync
      // Bus and key pins idle high, so reset there to avoid a false edge
      localparam logic IDLE_HIGH = (gi == IN_SCL) || (gi == IN_SDA) ||
                                   (gi == IN_KEY);
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          sync1_reg[gi] <= IDLE_HIGH;
          sync2_reg[gi] <= IDLE_HIGH;
          prev_reg[gi]  <= IDLE_HIGH;
        end else begin
          sync1_reg[gi] <= asyncIn[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          prev_reg[gi]  <= sync2_reg[gi];
        end
      end
      assign rise[gi] = sync2_reg[gi] & ~prev_reg[gi];
      assign fall[gi] = ~sync2_reg[gi] & prev_reg[gi];
    end
  endgenerate

  assign sclRise  = rise[IN_SCL];
  assign sclFall  = fall[IN_SCL];
  assign busStart = fall[IN_SDA] & sync2_reg[IN_SCL] & prev_reg[IN_SCL];
  assign busStop  = rise[IN_SDA] & sync2_reg[IN_SCL] & prev_reg[IN_SCL];
  assign byteDone = (bitCount_reg == BITS_PER_BYTE);
  assign wrStrobe = (state_reg == BUS_RX) && sclFall && byteDone &&
                    (phase_reg == PH_DATA);

  // Live status view
  always_comb begin
    liveStatus = 8'h00;
    liveStatus[BIT_CUR_ALARM] = sync2_reg[IN_CUR];
    liveStatus[BIT_THERMAL]   = sync2_reg[IN_THERM];
    liveStatus[BIT_INPUT_LOW] = sync2_reg[IN_LOWIN];
    liveStatus[BIT_ST_KEY]    = ~sync2_reg[IN_KEY];
    liveStatus[BIT_GOOD]      = sync2_reg[IN_GOOD];
    liveStatus[BIT_GEN1]      = sync2_reg[IN_GEN1];
    liveStatus[BIT_GEN0]      = sync2_reg[IN_GEN0];
  end

  // Register read mux
  always_comb begin
    case (pointer_reg)
      ADDR_EVENT_MASK:  rdData = mask_reg;
      ADDR_LIVE_STATUS: rdData = liveStatus;
      ADDR_EVENT_LATCH: rdData = event_reg;
      ADDR_FAULT_HIST:  rdData = fault_reg;
      ADDR_LOCK:        rdData = unlocked_reg ? LOCK_KEY : 8'h00;
      ADDR_THRESH_CFG:  rdData = thresh_reg;
      default:          rdData = 8'h00;
    endcase
  end

  // Event sources
  assign keyEvent = keyEdgeSelect ? rise[IN_KEY] : fall[IN_KEY];
  always_comb begin
    eventSet = 8'h00;
    eventSet[BIT_EV_LONG_PRESS] = rise[IN_LONG];
    eventSet[BIT_THERMAL]       = rise[IN_THERM];
    eventSet[BIT_INPUT_LOW]     = rise[IN_LOWIN];
    eventSet[BIT_EV_KEY]        = keyEvent;
    eventSet[BIT_EV_CURRENT]    = rise[IN_CUR];
    eventSet[BIT_GOOD]          = fall[IN_GOOD];
    eventSet[BIT_GEN1] = genInputActiveHigh[1] ? rise[IN_GEN1]
                                               : fall[IN_GEN1];
    eventSet[BIT_GEN0] = genInputActiveHigh[0] ? rise[IN_GEN0]
                                               : fall[IN_GEN0];
    eventClr = 8'h00;
    if (wrStrobe && pointer_reg == ADDR_EVENT_LATCH) begin
      eventClr = shift_reg;
    end
  end

  always_comb begin
    faultSet = 8'h00;
    faultSet[BIT_FL_RAMP]  = rise[IN_RAMP];
    faultSet[BIT_FL_SOFT]  = rise[IN_SOFT];
    faultSet[BIT_FL_INPUT] = rise[IN_GPCYC];
    faultSet[BIT_FL_LONG]  = cycleFire_reg;
    faultSet[BIT_FL_UV]    = rise[IN_UV];
    faultSet[BIT_FL_OC]    = rise[IN_OC];
    faultSet[BIT_FL_OT]    = rise[IN_OT];
    faultSet[BIT_FL_BOOT]  = bootPending_reg;
  end

  // Mask register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= MASK_RESET;
    end else if (wrStrobe && pointer_reg == ADDR_EVENT_MASK) begin
      mask_reg <= shift_reg;
    end
  end

  // Event latches, set wins over clear
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      event_reg <= 8'h00;
    end else begin
      event_reg <= (event_reg & ~eventClr) | eventSet;
    end
  end

  // Fault history
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      fault_reg       <= 8'h00;
      bootPending_reg <= 1'b1;
    end else begin
      bootPending_reg <= 1'b0;
      if (wrStrobe && pointer_reg == ADDR_FAULT_HIST) begin
        fault_reg <= shift_reg | faultSet;
      end else begin
        fault_reg <= fault_reg | faultSet;
      end
    end
  end

  // Lock and configuration region
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      unlocked_reg <= 1'b0;
    end else if (wrStrobe && pointer_reg == ADDR_LOCK) begin
      unlocked_reg <= (shift_reg == LOCK_KEY);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      thresh_reg <= THRESH_RESET;
    end else if (wrStrobe && unlocked_reg &&
                 pointer_reg == ADDR_THRESH_CFG) begin
      thresh_reg <= shift_reg;
    end
  end

  // Long-press power cycle timer, cancelled when the host clears bit 7
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cycleArmed_reg <= 1'b0;
      cycleCount_reg <= 32'h0;
      cycleFire_reg  <= 1'b0;
    end else begin
      cycleFire_reg <= 1'b0;
      if (eventSet[BIT_EV_LONG_PRESS]) begin
        cycleArmed_reg <= 1'b1;
        cycleCount_reg <= 32'h0;
      end else if (cycleArmed_reg) begin
        if (!event_reg[BIT_EV_LONG_PRESS]) begin
          cycleArmed_reg <= 1'b0;
        end else if (cycleCount_reg == CYCLE_DELAY - 1) begin
          cycleArmed_reg <= 1'b0;
          cycleFire_reg  <= 1'b1;
        end else begin
          cycleCount_reg <= cycleCount_reg + 32'h1;
        end
      end
    end
  end

  // Interrupt output
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irqN_reg <= 1'b1;
    end else begin
      irqN_reg <= ~|(event_reg & ~mask_reg);
    end
  end

  // Serial slave: address, pointer (write frames only), then data bytes with auto-increment
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= BUS_IDLE;
      phase_reg    <= PH_ADDR;
      bitCount_reg <= 4'h0;
      shift_reg    <= 8'h00;
      pointer_reg  <= 8'h00;
      readMode_reg <= 1'b0;
      sdaOe_reg    <= 1'b0;
    end else if (busStart) begin
      state_reg    <= BUS_RX;
      phase_reg    <= PH_ADDR;
      bitCount_reg <= 4'h0;
      sdaOe_reg    <= 1'b0;
    end else if (busStop) begin
      state_reg <= BUS_IDLE;
      sdaOe_reg <= 1'b0;
    end else begin
      case (state_reg)
        BUS_IDLE: begin
          sdaOe_reg <= 1'b0;
        end
        BUS_RX: begin
          if (sclRise && !byteDone) begin
            shift_reg    <= {shift_reg[6:0], sync2_reg[IN_SDA]};
            bitCount_reg <= bitCount_reg + 4'h1;
          end else if (sclFall && byteDone) begin
            bitCount_reg <= 4'h0;
            case (phase_reg)
              PH_ADDR: begin
                if (shift_reg[7:1] == SLAVE_ADDR) begin
                  readMode_reg <= shift_reg[0];
                  phase_reg    <= shift_reg[0] ? PH_DATA : PH_PTR;
                  state_reg    <= BUS_ACK;
                  sdaOe_reg    <= 1'b1;
                end else begin
                  state_reg <= BUS_IDLE;
                end
              end
              PH_PTR: begin
                pointer_reg <= shift_reg;
                phase_reg   <= PH_DATA;
                state_reg   <= BUS_ACK;
                sdaOe_reg   <= 1'b1;
              end
              default: begin
                pointer_reg <= pointer_reg + 8'h1;
                state_reg   <= BUS_ACK;
                sdaOe_reg   <= 1'b1;
              end
            endcase
          end
        end
        BUS_ACK: begin
          if (sclFall) begin
            if (readMode_reg) begin
              shift_reg   <= {rdData[6:0], 1'b0};
              sdaOe_reg   <= ~rdData[7];
              pointer_reg <= pointer_reg + 8'h1;
              bitCount_reg <= 4'h1;
              state_reg   <= BUS_TX;
            end else begin
              sdaOe_reg <= 1'b0;
              state_reg <= BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (sclFall) begin
            if (byteDone) begin
              sdaOe_reg <= 1'b0;
              state_reg <= BUS_MACK;
            end else begin
              sdaOe_reg    <= ~shift_reg[7];
              shift_reg    <= {shift_reg[6:0], 1'b0};
              bitCount_reg <= bitCount_reg + 4'h1;
            end
          end
        end
        BUS_MACK: begin
          if (sclRise && sync2_reg[IN_SDA]) begin
            state_reg <= BUS_IDLE;
          end else if (sclFall) begin
            shift_reg    <= {rdData[6:0], 1'b0};
            sdaOe_reg    <= ~rdData[7];
            pointer_reg  <= pointer_reg + 8'h1;
            bitCount_reg <= 4'h1;
            state_reg    <= BUS_TX;
          end
        end
        default: begin
          state_reg <= BUS_IDLE;
          sdaOe_reg <= 1'b0;
        end
      endcase
    end
  end

  // Output flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sdaOut            <= 1'b0;
      sdaOe             <= 1'b0;
      interruptOutN     <= 1'b1;
      powerCycleRequest <= 1'b0;
      thresholdCfg      <= THRESH_RESET;
    end else begin
      sdaOut            <= 1'b0;
      sdaOe             <= sdaOe_reg;
      interruptOutN     <= irqN_reg;
      powerCycleRequest <= cycleFire_reg;
      thresholdCfg      <= thresh_reg;
    end
  end

endmodule // event_status_lock_regs
`default_nettype wire

// File: hdl/event_status_lock_pkg.sv
package event_status_lock_pkg;
  localparam logic [7:0] ADDR_EVENT_MASK  = 8'h09;
  localparam logic [7:0] ADDR_LIVE_STATUS = 8'h0a;
  localparam logic [7:0] ADDR_EVENT_LATCH = 8'h0b;
  localparam logic [7:0] ADDR_FAULT_HIST  = 8'h0c;
  localparam logic [7:0] ADDR_LOCK        = 8'h0d;
  localparam logic [7:0] ADDR_THRESH_CFG  = 8'h0e;
  localparam logic [7:0] ADDR_REGION_LAST = 8'h2f;
  localparam logic [7:0] LOCK_KEY         = 8'h4a;
  localparam logic [7:0] MASK_RESET       = 8'h00;
  localparam logic [7:0] THRESH_RESET     = 8'ha5;
  localparam logic [6:0] SLAVE_ADDR_RESET = 7'h68;
  // Status, event and fault bit positions
  localparam int BIT_EV_LONG_PRESS = 7;
  localparam int BIT_CUR_ALARM     = 7;
  localparam int BIT_THERMAL       = 6;
  localparam int BIT_INPUT_LOW     = 5;
  localparam int BIT_EV_KEY        = 4;
  localparam int BIT_ST_KEY        = 3;
  localparam int BIT_EV_CURRENT    = 3;
  localparam int BIT_GOOD          = 2;
  localparam int BIT_GEN1          = 1;
  localparam int BIT_GEN0          = 0;
  localparam int BIT_FL_RAMP       = 7;
  localparam int BIT_FL_SOFT       = 6;
  localparam int BIT_FL_INPUT      = 5;
  localparam int BIT_FL_LONG       = 4;
  localparam int BIT_FL_UV         = 3;
  localparam int BIT_FL_OC         = 2;
  localparam int BIT_FL_OT         = 1;
  localparam int BIT_FL_BOOT       = 0;
  // Positions inside the synchronised input vector
  localparam int NUM_ASYNC   = 16;
  localparam int IN_SCL      = 15;
  localparam int IN_SDA      = 14;
  localparam int IN_KEY      = 13;
  localparam int IN_CUR      = 12;
  localparam int IN_THERM    = 11;
  localparam int IN_LOWIN    = 10;
  localparam int IN_GOOD     = 9;
  localparam int IN_GEN1     = 8;
  localparam int IN_GEN0     = 7;
  localparam int IN_LONG     = 6;
  localparam int IN_RAMP     = 5;
  localparam int IN_UV       = 4;
  localparam int IN_OC       = 3;
  localparam int IN_OT       = 2;
  localparam int IN_SOFT     = 1;
  localparam int IN_GPCYC    = 0;
  // Timing
  localparam int CLK_PERIOD_NS      = 20;
  localparam int CYCLE_DELAY_MS     = 1000;
  localparam int CYCLE_DELAY_CYCLES = CYCLE_DELAY_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [4:0] {
    BUS_IDLE = 5'b00001,
    BUS_RX   = 5'b00010,
    BUS_ACK  = 5'b00100,
    BUS_TX   = 5'b01000,
    BUS_MACK = 5'b10000
  } bus_state_t;
  typedef enum logic [2:0] {
    PH_ADDR = 3'b001,
    PH_PTR  = 3'b010,
    PH_DATA = 3'b100
  } bus_phase_t;
endpackage

// File: sim/event_status_lock_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module event_status_lock_regs_props #(
  parameter int unsigned CYCLE_DELAY = 200
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       sdaOut,
  input wire logic       sdaOe,
  input wire logic       longPressDetect,
  input wire logic       interruptOutN,
  input wire logic       powerCycleRequest,
  input wire logic [7:0] thresholdCfg
);
  logic [31:0] sincePress;
  logic        pressPrev;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Cycles since the last long press, saturating while idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sincePress <= '1;
      pressPrev  <= 1'b0;
    end else begin
      pressPrev <= longPressDetect;
      if (longPressDetect && !pressPrev) begin
        sincePress <= '0;
      end else if (sincePress != '1) begin
        sincePress <= sincePress + 32'h1;
      end
    end
  end
  cycle_pulse_a: assert property (
    powerCycleRequest |=> !powerCycleRequest)
    else $error("Power cycle request longer than one cycle");
  cycle_delay_a: assert property (
    powerCycleRequest |-> sincePress >= CYCLE_DELAY &&
      sincePress <= CYCLE_DELAY + 16)
    else $error("Power cycle request at wrong delay");
  press_quiet_a: assert property (
    $rose(longPressDetect) |-> !powerCycleRequest [*8])
    else $error("Power cycle request right after press");
  thresh_reset_a: assert property (
    $rose(nrst) |-> thresholdCfg == 8'ha5)
    else $error("Threshold reset value wrong");
  release_idle_a: assert property (
    $rose(nrst) |-> interruptOutN && !sdaOe && !powerCycleRequest)
    else $error("Outputs not idle after reset");
  thresh_write_a: assert property (
    $changed(thresholdCfg) |-> ##[0:6] sdaOe)
    else $error("Threshold changed outside an acked write");
  irq_release_a: assert property (
    $rose(interruptOutN) |-> sdaOe || $past(sdaOe))
    else $error("Interrupt released without a host write");
  sda_drain_a: assert property (
    sdaOut == 1'b0)
    else $error("Serial data driven high");
endmodule // event_status_lock_regs_props
bind event_status_lock_regs event_status_lock_regs_props #(
  .CYCLE_DELAY(CYCLE_DELAY)
) i_event_status_lock_regs_props (
  .ref_clk(ref_clk), .nrst(nrst), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .longPressDetect(longPressDetect), .interruptOutN(interruptOutN),
  .powerCycleRequest(powerCycleRequest), .thresholdCfg(thresholdCfg)
);
`default_nettype wire

// File: sim/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
  parameter logic [6:0] ADDR = 7'h68
) (
  input  wire logic       ref_clk,
  input  wire logic       sdaWire,
  output var  logic       scl,
  output var  logic       sdaLow,
  output var  logic       rdDone,
  output var  logic [7:0] rdData,
  output var  logic       nackSeen
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
    rdDone = 1'b0;
    rdData = 8'h00;
    nackSeen = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // One 160 ns bit, sampled late in the high phase
  task automatic bitIo(input logic b, output logic s);
    w(2);
    sdaLow = !b;
    w(2);
    scl = 1'b1;
    w(3);
    s = sdaWire;
    w(1);
    scl = 1'b0;
  endtask
  task automatic start();
    w(2);
    sdaLow = 1'b0;
    w(2);
    scl = 1'b1;
    w(4);
    sdaLow = 1'b1;
    w(4);
    scl = 1'b0;
  endtask
  // Clock stays high between frames
  task automatic stop();
    w(2);
    sdaLow = 1'b1;
    w(2);
    scl = 1'b1;
    w(4);
    sdaLow = 1'b0;
    w(4);
  endtask
  task automatic sendByte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitIo(d[i], s);
    bitIo(1'b1, s);
    if (s !== 1'b0) nackSeen = 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    start();
    sendByte({ADDR, 1'b0});
    sendByte(a);
    sendByte(d);
    stop();
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    logic       s;
    start();
    sendByte({ADDR, 1'b0});
    sendByte(a);
    start();
    sendByte({ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitIo(1'b1, s);
      d[i] = s;
    end
    bitIo(1'b1, s);
    stop();
    rdData = d;
    rdDone = 1'b1;
    w(1);
    rdDone = 1'b0;
  endtask
endmodule // i2c_host_model
`default_nettype wire

// File: sim/event_status_lock_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module event_status_lock_regs_tb;
  localparam int unsigned CD = 2000;
  logic ref_clk = 1'b0, nrst = 1'b0, scl, sdaLow, sdaIn, sdaOut, sdaOe;
  logic powerKeyPin = 1'b1, converterCurrentAlarmLive = 1'b0;
  logic thermalWarnLive = 1'b0, inputLowWarnLive = 1'b0;
  logic converterGoodLive = 1'b1, genInput1Level = 1'b0;
  logic genInput0Level = 1'b1, longPressDetect = 1'b0;
  logic rampupFailure = 1'b0, inputUndervoltageFault = 1'b0;
  logic converterOvercurrentFault = 1'b0, overtemperatureFault = 1'b0;
  logic softwarePowerCycleCtrl = 1'b0, inputCycleRequest = 1'b0;
  logic keyEdgeSelect = 1'b0, interruptOutN, powerCycleRequest;
  logic rdDone, nackSeen, seen;
  logic [1:0] genInputActiveHigh = 2'b10;
  logic [7:0] thresholdCfg, rdData, r, nk;
  logic [7:0] expQ[$];
  int         err_total = 0;
  int         tests_run = 0;

  always #10 ref_clk = ~ref_clk;
  assign sdaIn = !(sdaOe || sdaLow);

  event_status_lock_regs #(.CYCLE_DELAY(CD)) i_event_status_lock_regs (
    .ref_clk, .nrst, .scl, .sdaIn, .sdaOut, .sdaOe, .powerKeyPin,
    .converterCurrentAlarmLive, .thermalWarnLive, .inputLowWarnLive,
    .converterGoodLive, .genInput1Level, .genInput0Level, .longPressDetect,
    .rampupFailure, .inputUndervoltageFault, .converterOvercurrentFault,
    .overtemperatureFault, .softwarePowerCycleCtrl, .inputCycleRequest,
    .keyEdgeSelect, .genInputActiveHigh, .interruptOutN, .powerCycleRequest,
    .thresholdCfg);
  i2c_host_model i_i2c_host_model (.ref_clk, .sdaWire(sdaIn), .scl,
    .sdaLow, .rdDone, .rdData, .nackSeen);

  task automatic chkPin(input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chkReg(input logic [7:0] g);
    chkPin((expQ.size() > 0) ? expQ.pop_front() : 8'hxx, g);
  endtask
  always @(posedge rdDone) chkReg(rdData);
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_i2c_host_model.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expQ.push_back(e);
    i_i2c_host_model.rd(a);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_total++;
    stop_test();
  end

  initial begin
    void'($urandom(41017));
    w(12);
    nrst = 1'b1;
    w(10);
    chkPin(8'h01, {7'h0, interruptOutN});
    rd(8'h09, 8'h00);
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h01);
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'ha5);
    r = 8'($urandom);
    nk = {r[7:1], 1'b1};
    wr(8'h0e, 8'h3c);
    rd(8'h0e, 8'ha5);
    wr(8'h0d, 8'h4a);
    rd(8'h0d, 8'h4a);
    wr(8'h0e, r);
    rd(8'h0e, r);
    chkPin(r, thresholdCfg);
    wr(8'h0d, nk);
    rd(8'h0d, 8'h00);
    wr(8'h0e, ~r);
    rd(8'h0e, r);
    rd(8'h30, 8'h00);
    r = 8'($urandom);
    {converterCurrentAlarmLive, thermalWarnLive, inputLowWarnLive} = r[7:5];
    powerKeyPin = !r[3];
    {converterGoodLive, genInput1Level, genInput0Level} = r[2:0];
    w(8);
    rd(8'h0a, r & 8'hef);
    {converterCurrentAlarmLive, thermalWarnLive, inputLowWarnLive} = 3'h0;
    {powerKeyPin, converterGoodLive, genInput1Level, genInput0Level} = 4'hd;
    w(8);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h00);
    chkPin(8'h01, {7'h0, interruptOutN});
    {converterCurrentAlarmLive, thermalWarnLive, inputLowWarnLive} = 3'h7;
    {powerKeyPin, converterGoodLive, genInput1Level, genInput0Level} = 4'h2;
    w(8);
    rd(8'h0b, 8'h7f);
    chkPin(8'h00, {7'h0, interruptOutN});
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h7f);
    wr(8'h09, 8'h7f);
    rd(8'h09, 8'h7f);
    chkPin(8'h01, {7'h0, interruptOutN});
    wr(8'h09, 8'h00);
    wr(8'h0b, 8'h0f);
    rd(8'h0b, 8'h70);
    chkPin(8'h00, {7'h0, interruptOutN});
    wr(8'h0b, 8'h70);
    chkPin(8'h01, {7'h0, interruptOutN});
    converterGoodLive = 1'b1;
    keyEdgeSelect = 1'b1;
    powerKeyPin = 1'b1;
    w(8);
    rd(8'h0b, 8'h10);
    wr(8'h0b, 8'h10);
    {rampupFailure, softwarePowerCycleCtrl, inputCycleRequest} = 3'h7;
    {inputUndervoltageFault, converterOvercurrentFault} = 2'h3;
    overtemperatureFault = 1'b1;
    w(8);
    {rampupFailure, softwarePowerCycleCtrl, inputCycleRequest} = 3'h0;
    {inputUndervoltageFault, converterOvercurrentFault} = 2'h0;
    overtemperatureFault = 1'b0;
    rd(8'h0c, 8'hef);
    wr(8'h0c, 8'h00);
    rd(8'h0c, 8'h00);
    longPressDetect = 1'b1;
    w(8);
    longPressDetect = 1'b0;
    rd(8'h0b, 8'h80);
    chkPin(8'h00, {7'h0, interruptOutN});
    seen = 1'b0;
    for (int i = 0; i < CD + 100 && !seen; i++) begin
      w(1);
      seen = powerCycleRequest;
    end
    chkPin(8'h01, {7'h0, seen});
    rd(8'h0c, 8'h10);
    wr(8'h0b, 8'h80);
    longPressDetect = 1'b1;
    w(8);
    longPressDetect = 1'b0;
    w(20);
    wr(8'h0b, 8'h80);
    seen = 1'b0;
    repeat (CD + 100) begin
      w(1);
      seen = seen | powerCycleRequest;
    end
    chkPin(8'h00, {7'h0, seen});
    {converterCurrentAlarmLive, thermalWarnLive, inputLowWarnLive} = 3'h0;
    genInput1Level = 1'b0;
    w(8);
    nrst = 1'b0;
    w(4);
    nrst = 1'b1;
    w(10);
    chkPin(8'h01, {7'h0, interruptOutN});
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h01);
    rd(8'h0d, 8'h00);
    chkPin(8'ha5, thresholdCfg);
    chkPin(8'h00, {7'h0, nackSeen});
    stop_test();
  end
endmodule // event_status_lock_regs_tb
`default_nettype wire
